/* bit_sync.sv */
`timescale 1ns/1ps
module bit_sync #(
  parameter int width = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [width-1:0] d,
  output logic      [width-1:0] q
);
  logic [width-1:0] stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '1;
      q      <= '1;
    end else if (ce) begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule

/* debug_serial_unit.sv */
`timescale 1ns/1ps
module debug_serial_unit (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd_pin,
  output logic             txd_pin,
  output logic             eng_rx_line,
  input  wire logic        eng_tx_line,
  output logic             rx_enable,
  output logic             tx_enable,
  output logic             rx_abort,
  output logic             tx_abort,
  output logic [2:0]       check_bit_kind,
  output logic             check_bit_on,
  output logic [1:0]       channel_loop_select,
  input  wire logic        rx_char_strobe,
  input  wire logic [7:0]  rx_char_in,
  input  wire logic        rx_stop_err,
  input  wire logic        rx_check_err,
  output logic             tx_char_valid,
  output logic      [7:0]  tx_character,
  input  wire logic        tx_char_take,
  input  wire logic        tx_shifting,
  input  wire logic        rx_dma_end,
  input  wire logic        tx_dma_end,
  input  wire logic        tx_dma_empty,
  input  wire logic        rx_dma_full,
  input  wire logic        dcc_write_pending,
  input  wire logic        dcc_read_pending,
  output logic             irq
);
  logic [31:0] line_mode_config;
  logic [31:0] irq_mask;
  logic [31:0] status_word;
  logic [31:0] next_rdata;
  logic [7:0]  rx_character;
  logic        rx_flag;
  logic        thr_full;
  logic        overrun_flag;
  logic        stop_bit_error_flag;
  logic        check_bit_error_flag;
  logic        rx_char_ready;
  logic        tx_holding_free;
  logic        tx_all_drained;
  logic        rxd_sync;
  logic        setup_phase;
  logic        access_done;
  logic        wr_done;
  logic        rd_done;
  logic        mapped;
  logic        clear_cmd;
  logic        rx_take;
  logic        rhr_read;
  logic        thr_write;
  dsu_pkg::loop_mode_e loop_mode;

  bit_sync #(.width(1)) u_rxd_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     (rxd_pin),
    .q     (rxd_sync)
  );

  // apb: zero-wait slave, read data captured in the setup cycle
  assign setup_phase = psel && !penable;
  assign access_done = ce && psel && penable;
  assign wr_done     = access_done && pwrite;
  assign rd_done     = access_done && !pwrite;
  assign pready      = ce;

  always_comb begin
    unique case (paddr)
      dsu_pkg::ctrl_cmd_off,
      dsu_pkg::line_mode_off,
      dsu_pkg::irq_set_off,
      dsu_pkg::irq_clear_off,
      dsu_pkg::irq_view_off,
      dsu_pkg::line_status_off,
      dsu_pkg::rx_holding_off,
      dsu_pkg::tx_holding_off: mapped = 1'b1;
      default:                 mapped = 1'b0;
    endcase
  end

  assign pslverr   = psel && penable && !mapped;
  assign clear_cmd = wr_done && paddr == dsu_pkg::ctrl_cmd_off && pwdata[dsu_pkg::err_clear_bit];
  assign rhr_read  = rd_done && paddr == dsu_pkg::rx_holding_off;
  assign thr_write = wr_done && paddr == dsu_pkg::tx_holding_off;

  always_comb begin
    unique case (paddr)
      dsu_pkg::line_mode_off:   next_rdata = line_mode_config & dsu_pkg::line_mode_valid;
      dsu_pkg::irq_view_off:    next_rdata = irq_mask;
      dsu_pkg::line_status_off: next_rdata = status_word;
      dsu_pkg::rx_holding_off:  next_rdata = {24'h000000, rx_character};
      default:                  next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (ce && setup_phase && !pwrite) begin
      prdata <= next_rdata;
    end
  end

  // mode register: only the two documented fields are stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_mode_config <= dsu_pkg::line_mode_reset;
    end else if (wr_done && paddr == dsu_pkg::line_mode_off) begin
      line_mode_config <= pwdata & dsu_pkg::line_mode_valid;
    end
  end

  assign check_bit_kind      = line_mode_config[dsu_pkg::kind_lsb +: 3];
  assign check_bit_on        = !check_bit_kind[2];
  assign channel_loop_select = line_mode_config[dsu_pkg::loop_lsb +: 2];
  assign loop_mode           = dsu_pkg::loop_mode_e'(channel_loop_select);

  // pin routing for the three test modes
  always_comb begin
    unique case (loop_mode)
      dsu_pkg::loop_normal: begin
        txd_pin     = eng_tx_line;
        eng_rx_line = rxd_sync;
      end
      dsu_pkg::loop_echo: begin
        txd_pin     = rxd_sync;
        eng_rx_line = rxd_sync;
      end
      dsu_pkg::loop_local: begin
        txd_pin     = 1'b1;
        eng_rx_line = eng_tx_line;
      end
      dsu_pkg::loop_remote: begin
        txd_pin     = rxd_sync;
        eng_rx_line = 1'b1;
      end
    endcase
  end

  // receiver and transmitter enables from the control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_enable <= 1'b0;
      tx_enable <= 1'b0;
    end else if (wr_done && paddr == dsu_pkg::ctrl_cmd_off) begin
      if (pwdata[dsu_pkg::rx_reset_bit] || pwdata[dsu_pkg::rx_off_bit]) begin
        rx_enable <= 1'b0;
      end else if (pwdata[dsu_pkg::rx_on_bit]) begin
        rx_enable <= 1'b1;
      end
      if (pwdata[dsu_pkg::tx_reset_bit] || pwdata[dsu_pkg::tx_off_bit]) begin
        tx_enable <= 1'b0;
      end else if (pwdata[dsu_pkg::tx_on_bit]) begin
        tx_enable <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_abort <= 1'b0;
      tx_abort <= 1'b0;
    end else if (ce) begin
      rx_abort <= wr_done && paddr == dsu_pkg::ctrl_cmd_off && pwdata[dsu_pkg::rx_reset_bit];
      tx_abort <= wr_done && paddr == dsu_pkg::ctrl_cmd_off && pwdata[dsu_pkg::tx_reset_bit];
    end
  end

  // interrupt mask: set and clear registers, set wins if both hit one bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= dsu_pkg::irq_mask_reset;
    end else if (wr_done && paddr == dsu_pkg::irq_set_off) begin
      irq_mask <= irq_mask | (pwdata & dsu_pkg::irq_bits_valid);
    end else if (wr_done && paddr == dsu_pkg::irq_clear_off) begin
      irq_mask <= irq_mask & ~pwdata;
    end
  end

  // receive holding register
  assign rx_take = ce && rx_char_strobe && rx_enable && loop_mode != dsu_pkg::loop_remote;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_character <= dsu_pkg::char_reset;
    end else if (rx_take) begin
      rx_character <= rx_char_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_flag <= 1'b0;
    end else if (rx_take) begin
      rx_flag <= 1'b1;
    end else if (ce && (rhr_read || rx_abort || !rx_enable)) begin
      rx_flag <= 1'b0;
    end
  end

  assign rx_char_ready = rx_flag && rx_enable;

  // line error flags: a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_flag <= 1'b0;
    end else if (rx_take && rx_flag && !rhr_read) begin
      overrun_flag <= 1'b1;
    end else if (clear_cmd) begin
      overrun_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_bit_error_flag <= 1'b0;
    end else if (rx_take && rx_stop_err) begin
      stop_bit_error_flag <= 1'b1;
    end else if (clear_cmd) begin
      stop_bit_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      check_bit_error_flag <= 1'b0;
    end else if (rx_take && rx_check_err && check_bit_on) begin
      check_bit_error_flag <= 1'b1;
    end else if (clear_cmd) begin
      check_bit_error_flag <= 1'b0;
    end
  end

  // transmit holding register; a new write overwrites a waiting character
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_character <= dsu_pkg::char_reset;
    end else if (thr_write) begin
      tx_character <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_full <= 1'b0;
    end else if (ce) begin
      if (thr_write) begin
        thr_full <= 1'b1;
      end else if (tx_abort || (tx_char_valid && tx_char_take)) begin
        thr_full <= 1'b0;
      end
    end
  end

  assign tx_char_valid   = thr_full && tx_enable && loop_mode != dsu_pkg::loop_remote;
  assign tx_holding_free = tx_enable && !thr_full;
  assign tx_all_drained  = tx_enable && !thr_full && !tx_shifting;

  // status word, shared layout with the mask registers
  always_comb begin
    status_word                            = 32'h00000000;
    status_word[dsu_pkg::st_rx_ready]      = rx_char_ready;
    status_word[dsu_pkg::st_tx_free]       = tx_holding_free;
    status_word[dsu_pkg::st_rx_dma_done]   = rx_dma_end;
    status_word[dsu_pkg::st_tx_dma_done]   = tx_dma_end;
    status_word[dsu_pkg::st_overrun]       = overrun_flag;
    status_word[dsu_pkg::st_stop_err]      = stop_bit_error_flag;
    status_word[dsu_pkg::st_check_err]     = check_bit_error_flag;
    status_word[dsu_pkg::st_tx_drained]    = tx_all_drained;
    status_word[dsu_pkg::st_tx_dma_empty]  = tx_dma_empty;
    status_word[dsu_pkg::st_rx_dma_full]   = rx_dma_full;
    status_word[dsu_pkg::st_dcc_write]     = dcc_write_pending;
    status_word[dsu_pkg::st_dcc_read]      = dcc_read_pending;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(status_word & irq_mask);
    end
  end

  a_set_mask_bits: assert property (@(posedge clk) disable iff (!rst_n)
    wr_done && paddr == dsu_pkg::irq_set_off
    |=> (irq_mask & $past(pwdata) & dsu_pkg::irq_bits_valid)
        == ($past(pwdata) & dsu_pkg::irq_bits_valid)
        && (irq_mask & ~$past(pwdata)) == ($past(irq_mask) & ~$past(pwdata)))
    else $error("mask set write misbehaved");

  a_clear_mask_bits: assert property (@(posedge clk) disable iff (!rst_n)
    wr_done && paddr == dsu_pkg::irq_clear_off
    |=> (irq_mask & $past(pwdata)) == 32'h00000000
        && (irq_mask & ~$past(pwdata)) == ($past(irq_mask) & ~$past(pwdata)))
    else $error("mask clear write misbehaved");

  a_view_reads_mask: assert property (@(posedge clk) disable iff (!rst_n)
    ce && setup_phase && !pwrite && paddr == dsu_pkg::irq_view_off
    |=> prdata == $past(irq_mask))
    else $error("mask view read wrong");

  a_rx_char_load: assert property (@(posedge clk) disable iff (!rst_n)
    rx_take |=> rx_char_ready && rx_character == $past(rx_char_in))
    else $error("received character not held");

  a_rhr_read_clear: assert property (@(posedge clk) disable iff (!rst_n)
    rhr_read && !rx_take |=> !rx_char_ready)
    else $error("ready not cleared by read");

  a_tx_write_busy: assert property (@(posedge clk) disable iff (!rst_n)
    thr_write |=> !tx_holding_free && tx_character == $past(pwdata[7:0]))
    else $error("holding free after write");

  a_overrun_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    overrun_flag && !clear_cmd |=> overrun_flag)
    else $error("overrun dropped early");

  a_stop_err_sets: assert property (@(posedge clk) disable iff (!rst_n)
    rx_take && rx_stop_err |=> stop_bit_error_flag)
    else $error("stop-bit error lost");

  a_check_err_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    check_bit_error_flag && !clear_cmd |=> check_bit_error_flag)
    else $error("check-bit error dropped early");

  a_clear_errors: assert property (@(posedge clk) disable iff (!rst_n)
    clear_cmd && !rx_take |=> !overrun_flag && !stop_bit_error_flag && !check_bit_error_flag)
    else $error("error flags not cleared");

  a_drain_while_busy: assert property (@(posedge clk) disable iff (!rst_n)
    tx_shifting || !tx_enable |-> !tx_all_drained)
    else $error("drained while shifting or disabled");

  a_status_mirrors: assert property (@(posedge clk) disable iff (!rst_n)
    ce && setup_phase && !pwrite && paddr == dsu_pkg::line_status_off
    |=> prdata[31:30] == {$past(dcc_read_pending), $past(dcc_write_pending)}
        && prdata[12:11] == {$past(rx_dma_full), $past(tx_dma_empty)}
        && prdata[4:3] == {$past(tx_dma_end), $past(rx_dma_end)})
    else $error("status mirror bits wrong");

  a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> irq == |($past(status_word) & $past(irq_mask)))
    else $error("interrupt output wrong");

  a_mode_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    ce && setup_phase && !pwrite && paddr == dsu_pkg::line_mode_off
    |=> (prdata & ~dsu_pkg::line_mode_valid) == 32'h00000000)
    else $error("reserved mode bits not zero");

  a_kind_from_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_done && paddr == dsu_pkg::line_mode_off
    |=> check_bit_kind == $past(pwdata[11:9]) && check_bit_on == !$past(pwdata[11]))
    else $error("check-bit kind not taken");
endmodule

/* dsu_pkg.sv */
// Summary of operation
// - check_bit_kind: 000 even, 001 odd, 010 low, 011 high, 1xx none
// - channel_loop_select 15:14: normal, echo, local loopback, remote loopback
// - ones written to irq_enable_set set mask bits; zeros no effect
// - ones written to irq_enable_clear clear mask bits; zeros no effect
// - irq_enable_view reads back the current mask
// - enable, clear, view and status share one bit layout
// - rx_char_ready sets on character arrival, clears on read or disable
// - tx_holding_free low while a character waits or transmitter disabled
// - rx_dma_done mirrors receive channel end-of-transfer input
// - tx_dma_done mirrors transmit channel end-of-transfer input
// - overrun_flag sticky until clear_error_flags
// - stop-bit error flag sticky until clear_error_flags
// - check_bit_error_flag sticky until clear_error_flags
// - tx_all_drained high only when holding and shifter empty and enabled
// - tx_dma_buffer_empty mirrors transmit channel buffer-empty input
// - rx_dma_buffer_full mirrors receive channel buffer-full input
// - status bit 30 mirrors dcc_write_pending
// - status bit 31 mirrors dcc_read_pending
// - rx_holding returns last character in bits 7:0
// - clear_error_flags clears overrun, stop-bit and check-bit errors
package dsu_pkg;
  localparam logic [7:0]  ctrl_cmd_off     = 8'h00;
  localparam logic [7:0]  line_mode_off    = 8'h04;
  localparam logic [7:0]  irq_set_off      = 8'h08;
  localparam logic [7:0]  irq_clear_off    = 8'h0c;
  localparam logic [7:0]  irq_view_off     = 8'h10;
  localparam logic [7:0]  line_status_off  = 8'h14;
  localparam logic [7:0]  rx_holding_off   = 8'h18;
  localparam logic [7:0]  tx_holding_off   = 8'h1c;

  localparam int          rx_reset_bit     = 2;
  localparam int          tx_reset_bit     = 3;
  localparam int          rx_on_bit        = 4;
  localparam int          rx_off_bit       = 5;
  localparam int          tx_on_bit        = 6;
  localparam int          tx_off_bit       = 7;
  localparam int          err_clear_bit    = 8;

  localparam int          kind_lsb         = 9;
  localparam int          loop_lsb         = 14;
  localparam logic [31:0] line_mode_valid  = 32'h0000ce00;
  localparam logic [31:0] line_mode_reset  = 32'h00000000;

  localparam int          st_rx_ready      = 0;
  localparam int          st_tx_free       = 1;
  localparam int          st_rx_dma_done   = 3;
  localparam int          st_tx_dma_done   = 4;
  localparam int          st_overrun       = 5;
  localparam int          st_stop_err      = 6;
  localparam int          st_check_err     = 7;
  localparam int          st_tx_drained    = 9;
  localparam int          st_tx_dma_empty  = 11;
  localparam int          st_rx_dma_full   = 12;
  localparam int          st_dcc_write     = 30;
  localparam int          st_dcc_read      = 31;
  localparam logic [31:0] irq_bits_valid   = 32'hc0001afb;
  localparam logic [31:0] irq_mask_reset   = 32'h00000000;
  localparam logic [7:0]  char_reset       = 8'h00;
  localparam int          sync_stages      = 2;

  typedef enum logic [1:0] {
    loop_normal,
    loop_echo,
    loop_local,
    loop_remote
  } loop_mode_e;
endpackage

/* engine_model.sv */
`timescale 1ns/1ps
module engine_model #(
  parameter int shift_len = 20
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rx_go,
  input  wire logic [9:0] rx_word,
  input  wire logic       hold_take,
  input  wire logic       tx_char_valid,
  input  wire logic [7:0] tx_character,
  output logic            rx_char_strobe,
  output logic [7:0]      rx_char_in,
  output logic            rx_stop_err,
  output logic            rx_check_err,
  output logic            tx_char_take,
  output logic            tx_shifting,
  output logic            eng_tx_line
);
  logic [7:0] shift_reg;
  int         count;

  // data and error lines change every cycle outside a strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {rx_char_strobe, rx_check_err, rx_stop_err, rx_char_in} <= 11'h000;
    end else if (rx_go) begin
      {rx_char_strobe, rx_check_err, rx_stop_err, rx_char_in} <= {1'b1, rx_word};
    end else begin
      rx_char_strobe <= 1'b0;
      {rx_check_err, rx_stop_err, rx_char_in} <= ~{rx_check_err, rx_stop_err, rx_char_in};
    end
  end

  // hold_take stalls the engine so a written character keeps waiting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_char_take <= 1'b0;
      count <= 0;
      shift_reg <= 8'h00;
    end else begin
      tx_char_take <= tx_char_valid && !hold_take && count == 0 && !tx_char_take;
      if (tx_char_take) begin
        shift_reg <= tx_character;
        count <= shift_len;
      end else if (count != 0) begin
        count <= count - 1;
        shift_reg <= {1'b1, shift_reg[7:1]};
      end
    end
  end

  assign tx_shifting = count != 0;
  assign eng_tx_line = tx_shifting ? shift_reg[0] : 1'b1;
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic        rxd_pin = 1'b1;
  logic        rx_go = 1'b0;
  logic [9:0]  rx_word = 10'h000;
  logic        hold_take = 1'b0;
  logic [5:0]  mirr = 6'h00;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, last_err, txd_pin, eng_rx_line, eng_tx_line, irq;
  logic        strobe, stop_e, check_e, valid, take, shifting, kind_on, rx_en, tx_en;
  logic [7:0]  rx_char, tx_char;
  logic [2:0]  kind;
  logic [1:0]  loop_sel;
  int          err_total = 0;
  int          check_count = 0;
  int          mbit [6] = '{3, 4, 11, 12, 30, 31};

  always #4 clk = ~clk;

  debug_serial_unit i_dut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .eng_rx_line(eng_rx_line), .eng_tx_line(eng_tx_line),
    .rx_enable(rx_en), .tx_enable(tx_en), .rx_abort(), .tx_abort(), .check_bit_kind(kind),
    .check_bit_on(kind_on), .channel_loop_select(loop_sel), .rx_char_strobe(strobe),
    .rx_char_in(rx_char), .rx_stop_err(stop_e), .rx_check_err(check_e), .tx_char_valid(valid),
    .tx_character(tx_char), .tx_char_take(take), .tx_shifting(shifting), .rx_dma_end(mirr[0]),
    .tx_dma_end(mirr[1]), .tx_dma_empty(mirr[2]), .rx_dma_full(mirr[3]),
    .dcc_write_pending(mirr[4]), .dcc_read_pending(mirr[5]), .irq(irq));

  engine_model i_eng (
    .clk(clk), .rst_n(rst_n), .rx_go(rx_go), .rx_word(rx_word), .hold_take(hold_take),
    .tx_char_valid(valid), .tx_character(tx_char), .rx_char_strobe(strobe), .rx_char_in(rx_char),
    .rx_stop_err(stop_e), .rx_check_err(check_e), .tx_char_take(take), .tx_shifting(shifting),
    .eng_tx_line(eng_tx_line));

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) err_total++;
    rd = prdata;
    last_err = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask

  task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk_reg(name, exp, rd);
  endtask

  // word is {check error, stop error, character}
  task automatic send(input logic [9:0] w);
    rx_go <= 1'b1;
    rx_word <= w;
    @(posedge clk);
    rx_go <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    err_total++;
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk("mode", 8'h04, 32'h00000000);
    rchk("mask", 8'h10, 32'h00000000);
    rchk("status", 8'h14, 32'h00000000);
    rchk("ctrl", 8'h00, 32'h00000000);
    rchk("unmapped", 8'h20, 32'h00000000);
    chk_bit("pslverr", 1'b1, last_err);
    $display("test reset done");
    apb(1'b1, 8'h04, 32'hffffffff);
    rchk("mode bits", 8'h04, 32'h0000ce00);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h04, (i << 9) | ((i % 4) << 14));
      chk_reg("kind", 32'(i), {29'h0, kind});
      chk_bit("kind on", !i[2], kind_on);
      chk_reg("loop", 32'(i % 4), {30'h0, loop_sel});
    end
    apb(1'b1, 8'h04, 32'h00004000);
    rxd_pin <= 1'b0;
    repeat (4) @(posedge clk);
    chk_bit("echo txd", 1'b0, txd_pin);
    apb(1'b1, 8'h04, 32'h00008000);
    chk_bit("local txd", 1'b1, txd_pin);
    chk_bit("local rx", eng_tx_line, eng_rx_line);
    apb(1'b1, 8'h04, 32'h0000c000);
    chk_bit("remote txd", 1'b0, txd_pin);
    chk_bit("remote rx", 1'b1, eng_rx_line);
    rxd_pin <= 1'b1;
    apb(1'b1, 8'h04, 32'h00000000);
    $display("test mode done");
    apb(1'b1, 8'h08, 32'hffffffff);
    rchk("mask set", 8'h10, 32'hc0001afb);
    apb(1'b1, 8'h0c, 32'h00000081);
    rchk("mask clear", 8'h10, 32'hc0001a7a);
    apb(1'b1, 8'h08, 32'h00000000);
    apb(1'b1, 8'h0c, 32'h00000000);
    apb(1'b1, 8'h10, 32'h00000000);
    rchk("mask hold", 8'h10, 32'hc0001a7a);
    apb(1'b1, 8'h0c, 32'hffffffff);
    apb(1'b1, 8'h08, 32'h40000000);
    rchk("mask one", 8'h10, 32'h40000000);
    for (int i = 0; i < 6; i++) begin
      mirr <= 6'h01 << i;
      rchk("status mirror", 8'h14, 32'h1 << mbit[i]);
      chk_bit("irq mirror", i == 4, irq);
    end
    mirr <= 6'h00;
    $display("test mask done");
    apb(1'b1, 8'h0c, 32'hffffffff);
    apb(1'b1, 8'h08, 32'h00000001);
    apb(1'b1, 8'h00, 32'h00000010);
    chk_bit("rx enable", 1'b1, rx_en);
    send(10'h0a5);
    rchk("rx ready", 8'h14, 32'h00000001);
    chk_bit("irq rx", 1'b1, irq);
    rchk("rx char", 8'h18, 32'h000000a5);
    rchk("rx read", 8'h14, 32'h00000000);
    chk_bit("irq idle", 1'b0, irq);
    send(10'h03c);
    send(10'h35a);
    rchk("rx errors", 8'h14, 32'h000000e1);
    rchk("rx last", 8'h18, 32'h0000005a);
    rchk("errors held", 8'h14, 32'h000000e0);
    apb(1'b1, 8'h00, 32'h00000100);
    rchk("errors clear", 8'h14, 32'h00000000);
    apb(1'b1, 8'h04, 32'h00000800);
    send(10'h211);
    rchk("no check bit", 8'h14, 32'h00000001);
    rchk("rx none", 8'h18, 32'h00000011);
    apb(1'b1, 8'h04, 32'h00000000);
    send(10'h042);
    apb(1'b1, 8'h00, 32'h00000020);
    rchk("rx off", 8'h14, 32'h00000000);
    chk_bit("rx disable", 1'b0, rx_en);
    $display("test receive done");
    apb(1'b1, 8'h00, 32'h00000040);
    rchk("tx on", 8'h14, 32'h00000202);
    hold_take <= 1'b1;
    apb(1'b1, 8'h1c, 32'h000001ff);
    chk_reg("tx char", 32'h000000ff, {24'h0, tx_char});
    rchk("tx wait", 8'h14, 32'h00000000);
    hold_take <= 1'b0;
    repeat (3) @(posedge clk);
    rchk("tx shift", 8'h14, 32'h00000002);
    chk_bit("normal txd", eng_tx_line, txd_pin);
    repeat (25) @(posedge clk);
    rchk("tx drained", 8'h14, 32'h00000202);
    hold_take <= 1'b1;
    apb(1'b1, 8'h1c, 32'h00000055);
    apb(1'b1, 8'h00, 32'h00000008);
    chk_bit("tx reset", 1'b0, tx_en);
    apb(1'b1, 8'h00, 32'h00000040);
    rchk("tx aborted", 8'h14, 32'h00000202);
    hold_take <= 1'b0;
    apb(1'b1, 8'h00, 32'h00000080);
    rchk("tx off", 8'h14, 32'h00000000);
    $display("test transmit done");
    stop_test();
  end
endmodule
